// ==== logic/das_defs.svh ====
// timing counts, bit positions and reset values of the dual converter control
`ifndef DAS_DEFS_SVH
`define DAS_DEFS_SVH

// serial clock falling edge counts since the chip-select fall
`define DAS_CNT_W        6
`define DAS_CNT_ZERO     6'h00
`define DAS_GLITCH_EDGES 6'h02
`define DAS_KEEP_EDGES   6'h0a
`define DAS_TRACK_EDGES  6'h0d
`define DAS_CONV_EDGES   6'h0e
`define DAS_HALF_EDGES   6'h10
`define DAS_LAST_EDGE    6'h1f
`define DAS_DUAL_EDGES   6'h20

// bit positions inside one 16-bit half of the frame
`define DAS_ID_POS       4'h1
`define DAS_MSB_POS      4'h2
`define DAS_LSB_POS      4'hd

// result and buffer sizes
`define DAS_RES_W        12
`define DAS_FIFO_DEPTH   16

// power-up time from partial power-down, longest figure, rounded down
`define DAS_CLK_MHZ      100
`define DAS_PWRUP_NS     1000
`define DAS_PWRUP_CYC    ((`DAS_PWRUP_NS * `DAS_CLK_MHZ) / 1000)
`define DAS_FULL_CYC     1000
`define DAS_PWR_W        16

`endif

// ==== logic/das_pkg.sv ====
// types shared by the dual converter control
package das_pkg;
   typedef enum logic [1:0] {
      DAS_NORMAL  = 2'h0,
      DAS_PARTIAL = 2'h1,
      DAS_FULL    = 2'h3
   } das_mode_t;

   typedef enum logic [1:0] {
      DAS_IDLE = 2'h0,
      DAS_RUN  = 2'h1,
      DAS_DONE = 2'h3
   } das_frm_t;

   typedef struct packed {
      logic [11:0] a;
      logic [11:0] b;
   } das_res_t;

   typedef struct packed {
      logic analog_on;
      logic ref_on;
      logic hold;
   } das_ana_t;
endpackage

// ==== logic/das_fifo.sv ====
// result buffer between the converter core and the serial shifter
`timescale 1ns/100ps
module das_fifo #(
   parameter int P_WIDTH = 24,
   parameter int P_DEPTH = 16
) (
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   input  wire logic [P_WIDTH-1:0] i_data,
   input  wire logic               i_valid,
   output logic                    o_ready,
   output logic [P_WIDTH-1:0]      o_data,
   output logic                    o_valid,
   input  wire logic               i_ready
);
   localparam int AW = $clog2(P_DEPTH);

   logic [P_WIDTH-1:0] mem [P_DEPTH];
   logic [AW-1:0]      wr_q;
   logic [AW-1:0]      rd_q;
   logic [AW:0]        cnt_q;
   logic               push;
   logic               pop;

   // honest full and empty from the fill count
   assign o_ready = (cnt_q != (AW+1)'(P_DEPTH));
   assign o_valid = (cnt_q != '0);
   assign o_data  = mem[rd_q];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   // storage write
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_q] <= i_data;
      end
   end

   // pointers wrap at the depth
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(P_DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(P_DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
      end
   end

   // fill count
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// ==== logic/das_ctrl.sv ====
// serial frame, power mode and readout control of the dual converter
//
// Operation
// R01: chip-select fall samples, converts, drives outputs
// R02: one result needs fourteen serial clocks
// R03: host holds select low ten edges
// R04: rise at edges ten to thirteen aborts
// R05: zero, id bit, then twelve result bits
// R06: after fourteen, outputs drive until select rises
// R07: two trailing zeros in sixteen-clock burst
// R08: second half carries the other converter
// R09: identification bit precedes each result
// R10: dual read floats at edge thirty-two
// R11: host may idle select low afterwards
// R12: host waits idle gap before next frame
// R13: normal, rise at two to nine: partial
// R14: rise before edge two keeps normal
// R15: partial keeps reference only; full all off
// R16: dummy frame past ten powers up
// R17: partial, early rise stays partial
// R18: partial, rise two to nine: full
// R19: power-down needs no further serial clocks
// R20: host waits full power-up before converting
// R21: track resumes at rise after edge thirteen
// R22: host may sample on rising edges
// R23: count falling edges, decide on select rise
`timescale 1ns/100ps
`include "das_defs.svh"
module das_ctrl #(
   parameter int P_RES_W     = `DAS_RES_W,
   parameter int P_DEPTH     = `DAS_FIFO_DEPTH,
   parameter int P_PWRUP_CYC = `DAS_PWRUP_CYC,
   parameter int P_FULL_CYC  = `DAS_FULL_CYC
) (
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   input  wire logic              i_cs_n,
   input  wire logic              i_sclk,
   input  wire das_pkg::das_res_t i_res,
   input  wire logic              i_res_valid,
   output logic                   o_res_ready,
   output logic                   o_serial_out_first,
   output logic                   o_serial_out_first_oe_n,
   output logic                   o_serial_out_second,
   output logic                   o_serial_out_second_oe_n,
   output das_pkg::das_ana_t      o_ana,
   output logic                   o_conv_start,
   output logic                   o_conv_abort,
   output logic                   o_pwr_ok,
   output das_pkg::das_mode_t     o_mode
);
   import das_pkg::*;

   localparam int CW = `DAS_CNT_W;
   localparam int PW = `DAS_PWR_W;

   logic [2:0]     cs_sync_q;
   logic [2:0]     sclk_sync_q;
   logic           cs_fall;
   logic           cs_rise;
   logic           sclk_fall;
   logic           sclk_rise;
   logic [CW-1:0]  cnt_q;
   logic [CW-1:0]  cnt_nx;
   das_frm_t       st_q;
   das_mode_t      mode_q;
   das_res_t       res_q;
   das_res_t       fifo_data;
   logic           fifo_valid;
   logic           hold_q;
   das_ana_t       ana_d;
   das_ana_t       ana_q;
   logic [PW-1:0]  pwr_q;
   logic           start_q;
   logic           abort_q;
   logic           mid_win;
   logic           keep_win;
   logic [1:0]     bit_q;
   logic [1:0]     oe_n_q;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge finders
   ////////////////////////////////////////////////////////////////////

   // two flops per pin, the third only feeds the edge finders
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cs_sync_q   <= 3'h7;
         sclk_sync_q <= 3'h7; // idle-high clock gives no false edge
      end else begin
         cs_sync_q   <= {cs_sync_q[1:0], i_cs_n};
         sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
      end
   end

   // edges seen between the second and third flops
   assign cs_fall   = cs_sync_q[2] && !cs_sync_q[1];
   assign cs_rise   = !cs_sync_q[2] && cs_sync_q[1];
   assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
   assign sclk_rise = !sclk_sync_q[2] && sclk_sync_q[1];

   ////////////////////////////////////////////////////////////////////
   // result buffer, one pair taken per frame
   ////////////////////////////////////////////////////////////////////

   das_fifo #(
      .P_WIDTH ($bits(das_res_t)),
      .P_DEPTH (P_DEPTH)
   ) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_data  (i_res),
      .i_valid (i_res_valid),
      .o_ready (o_res_ready),
      .o_data  (fifo_data),
      .o_valid (fifo_valid),
      .i_ready (cs_fall)
   );

   // result frozen at the frame start, zeros when none is buffered
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         res_q <= '0;
      end else if (cs_fall) begin
         res_q <= fifo_valid ? fifo_data : '0; // see R01
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame state and edge counter
   ////////////////////////////////////////////////////////////////////

   // frame runs from select fall to select rise
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_q <= DAS_IDLE;
      end else begin
         case (st_q)
            DAS_IDLE: begin
               if (cs_fall) begin
                  st_q <= DAS_RUN;
               end
            end
            DAS_RUN: begin
               if (cs_rise) begin
                  st_q <= DAS_IDLE;
               end else if (sclk_fall && cnt_q == `DAS_LAST_EDGE) begin
                  st_q <= DAS_DONE; // see R10
               end
            end
            DAS_DONE: begin
               if (cs_rise) begin
                  st_q <= DAS_IDLE;
               end
            end
            default: begin
               st_q <= DAS_IDLE;
            end
         endcase
      end
   end

   // falling edges since select fell, held at thirty-two
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_q <= `DAS_CNT_ZERO;
      end else if (cs_fall) begin
         cnt_q <= `DAS_CNT_ZERO; // see R23
      end else if (st_q == DAS_RUN && sclk_fall) begin
         cnt_q <= cnt_nx; // see R23
      end
   end

   assign cnt_nx = cnt_q + CW'(1);

   ////////////////////////////////////////////////////////////////////
   // power mode decided at the select rise
   ////////////////////////////////////////////////////////////////////

   // count windows that pick the next mode
   assign mid_win  = (cnt_q >= `DAS_GLITCH_EDGES) &&
                     (cnt_q < `DAS_KEEP_EDGES);
   assign keep_win = (cnt_q >= `DAS_KEEP_EDGES);

   // no serial clock is needed after the rise to change mode
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mode_q <= DAS_NORMAL;
      end else if (cs_rise && st_q != DAS_IDLE) begin // see R14, R17
         case (mode_q)
            DAS_NORMAL: begin
               if (mid_win) begin
                  mode_q <= DAS_PARTIAL; // see R13, R19
               end
            end
            DAS_PARTIAL: begin
               if (mid_win) begin
                  mode_q <= DAS_FULL; // see R18, R19
               end else if (keep_win) begin
                  mode_q <= DAS_NORMAL; // see R16
               end
            end
            DAS_FULL: begin
               if (keep_win) begin
                  mode_q <= DAS_NORMAL; // see R16
               end
            end
            default: begin
               mode_q <= DAS_NORMAL;
            end
         endcase
      end
   end

   // conversion aborted when select rises before edge fourteen
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         abort_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         abort_q <= cs_rise && st_q == DAS_RUN &&
                    cnt_q < `DAS_CONV_EDGES; // see R02, R04, R13
         start_q <= cs_fall; // see R01
      end
   end

   ////////////////////////////////////////////////////////////////////
   // analog power and track-and-hold
   ////////////////////////////////////////////////////////////////////

   // hold from select fall until the rise after edge thirteen
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         hold_q <= 1'b0;
      end else if (cs_fall) begin
         hold_q <= 1'b1; // see R01
      end else if (cs_rise) begin
         hold_q <= 1'b0;
      end else if (sclk_rise && cnt_q >= `DAS_TRACK_EDGES) begin
         hold_q <= 1'b0; // see R21
      end
   end

   // a frame powers the core up; the rise drops it back if asleep
   always_comb begin
      ana_d.analog_on = (mode_q == DAS_NORMAL) ||
                        (st_q != DAS_IDLE); // see R15, R17
      ana_d.ref_on    = (mode_q != DAS_FULL) || (st_q != DAS_IDLE);
      ana_d.hold      = hold_q;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ana_q <= '{analog_on: 1'b1, ref_on: 1'b1, hold: 1'b0};
      end else begin
         ana_q <= ana_d; // see R15
      end
   end

   // power-up timer, longer when the reference was off too
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pwr_q <= '0;
      end else if (!ana_d.analog_on) begin
         pwr_q <= '0;
      end else if (!ana_q.analog_on) begin
         pwr_q <= ana_q.ref_on ? PW'(P_PWRUP_CYC)
                               : PW'(P_FULL_CYC); // see R16
      end else if (pwr_q != '0) begin
         pwr_q <= pwr_q - PW'(1);
      end
   end

   assign o_ana        = ana_q;
   assign o_pwr_ok     = ana_q.analog_on && (pwr_q == '0);
   assign o_mode       = mode_q;
   assign o_conv_start = start_q;
   assign o_conv_abort = abort_q;

   ////////////////////////////////////////////////////////////////////
   // serial data lines
   ////////////////////////////////////////////////////////////////////

   // bit at position n of the frame for one line
   function automatic logic bit_at(input logic [CW-1:0] n,
                                   input logic          line_b,
                                   input das_res_t      r);
      logic [3:0]         p;
      logic               src_b;
      logic [P_RES_W-1:0] w;
      p      = n[3:0];
      src_b  = line_b ^ n[4];
      w      = src_b ? r.b : r.a;
      bit_at = 1'b0;
      if (n >= `DAS_DUAL_EDGES) begin
         bit_at = 1'b0;
      end else if (p == `DAS_ID_POS) begin
         bit_at = src_b; // see R09
      end else if (p >= `DAS_MSB_POS && p <= `DAS_LSB_POS) begin
         bit_at = w[`DAS_LSB_POS - p]; // see R05
      end
      return bit_at;
   endfunction

   // one shifter and enable per line; line 1 starts with result b
   for (genvar i = 0; i < 2; i++) begin : g_line
      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            bit_q[i] <= 1'b0;
         end else if (cs_fall) begin
            bit_q[i] <= 1'b0; // see R05
         end else if (st_q == DAS_RUN && sclk_fall) begin
            bit_q[i] <= bit_at(cnt_nx, 1'(i), res_q); // see R07, R08
         end
      end

      always_ff @(posedge i_mclk) begin
         if (i_rst) begin
            oe_n_q[i] <= 1'b1;
         end else if (cs_fall) begin
            oe_n_q[i] <= 1'b0; // see R01
         end else if (cs_rise) begin
            oe_n_q[i] <= 1'b1; // see R04, R06
         end else if (st_q == DAS_RUN && sclk_fall &&
                      cnt_q == `DAS_LAST_EDGE) begin
            oe_n_q[i] <= 1'b1; // see R10
         end
      end
   end

   assign o_serial_out_first       = bit_q[0];
   assign o_serial_out_second      = bit_q[1];
   assign o_serial_out_first_oe_n  = oe_n_q[0];
   assign o_serial_out_second_oe_n = oe_n_q[1];

   ////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////

   localparam int PWR_MAX = 102;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // select rises with the count in the power-down window
   sequence s_rise_mid;
      cs_rise && st_q != DAS_IDLE && mid_win;
   endsequence

   // select rises after the dummy frame passed edge ten
   sequence s_rise_keep;
      cs_rise && st_q != DAS_IDLE && keep_win;
   endsequence

   property p_start;
      cs_fall |=> hold_q && !oe_n_q[0] && !oe_n_q[1] && start_q
                  && cnt_q == `DAS_CNT_ZERO && bit_q == 2'h0;
   endproperty
   a_start: assert property (p_start) // see R01, R05, R23
      else $error("frame start not handled");

   property p_abort_keep;
      (mode_q == DAS_NORMAL) and s_rise_keep and
      (cnt_q < `DAS_CONV_EDGES) |=> mode_q == DAS_NORMAL
      && abort_q && oe_n_q == 2'h3;
   endproperty
   a_abort_keep: assert property (p_abort_keep) // see R04
      else $error("late abort wrong");

   property p_drive_on;
      (st_q == DAS_RUN && !cs_rise && cnt_q >= `DAS_CONV_EDGES &&
       cnt_q < `DAS_LAST_EDGE) |=> oe_n_q == 2'h0;
   endproperty
   a_drive_on: assert property (p_drive_on) // see R06
      else $error("line floated before select rise");

   property p_trail;
      (st_q == DAS_RUN && sclk_fall && !cs_rise && !cs_fall &&
       (cnt_q == `DAS_LSB_POS || cnt_q == `DAS_CONV_EDGES))
      |=> bit_q == 2'h0;
   endproperty
   a_trail: assert property (p_trail) // see R07
      else $error("trailing bits not zero");

   property p_swap_id;
      (st_q == DAS_RUN && sclk_fall && !cs_rise && !cs_fall &&
       cnt_q == `DAS_HALF_EDGES) |=> bit_q == 2'h1;
   endproperty
   a_swap_id: assert property (p_swap_id) // see R08, R09
      else $error("second half id bit wrong");

   property p_float32;
      (st_q == DAS_RUN && sclk_fall && !cs_rise &&
       cnt_q == `DAS_LAST_EDGE) |=> oe_n_q == 2'h3 ##1 oe_n_q == 2'h3;
   endproperty
   a_float32: assert property (p_float32) // see R10
      else $error("no float at edge thirty-two");

   property p_to_partial;
      (mode_q == DAS_NORMAL) and s_rise_mid |=>
         mode_q == DAS_PARTIAL && oe_n_q == 2'h3 ##1 !ana_q.analog_on;
   endproperty
   a_to_partial: assert property (p_to_partial) // see R13, R19
      else $error("partial power-down not entered");

   property p_glitch;
      (cs_rise && st_q != DAS_IDLE && cnt_q < `DAS_GLITCH_EDGES)
      |=> mode_q == $past(mode_q);
   endproperty
   a_glitch: assert property (p_glitch) // see R14, R17
      else $error("glitch changed mode");

   property p_to_full;
      (mode_q == DAS_PARTIAL) and s_rise_mid |=>
         mode_q == DAS_FULL ##1 !ana_q.ref_on;
   endproperty
   a_to_full: assert property (p_to_full) // see R18
      else $error("full power-down not entered");

   property p_sleep_pwr;
      (st_q == DAS_IDLE && ana_q == ana_d && mode_q != DAS_NORMAL)
      |-> !ana_q.analog_on && (ana_q.ref_on == (mode_q == DAS_PARTIAL));
   endproperty
   a_sleep_pwr: assert property (p_sleep_pwr) // see R15
      else $error("power-down supplies wrong");

   property p_wake;
      (mode_q == DAS_PARTIAL) and s_rise_keep |=>
         mode_q == DAS_NORMAL ##[1:PWR_MAX] o_pwr_ok;
   endproperty
   a_wake: assert property (p_wake) // see R16
      else $error("power-up from partial too slow");

   property p_track;
      (hold_q && sclk_rise && !cs_fall && cnt_q >= `DAS_TRACK_EDGES)
      |=> !hold_q;
   endproperty
   a_track: assert property (p_track) // see R21
      else $error("track not resumed");
endmodule

// ==== tb/das_host_model.sv ====
// host serial port model that drives chip-select and the serial clock
`timescale 1ns/100ps
module das_host_model #(
   parameter int P_GAP = 12
) (
   input  wire logic i_mclk,
   output logic      o_cs_n,
   output logic      o_sclk,
   input  wire logic i_first,
   input  wire logic i_first_oe_n,
   input  wire logic i_second,
   input  wire logic i_second_oe_n,
   input  wire logic i_hold
);
   logic [31:0] bits_a;
   logic [31:0] bits_b;
   logic [31:0] drv;
   logic [31:0] hold_v;
   logic        float_end;

   // serial clock rests high and select rests high outside frames
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
   end

   // half of the 80 ns serial clock period
   task automatic half();
      repeat (4) @(negedge i_mclk);
   endtask

   // one frame of n falling edges, lingering while still selected
   task automatic frame(input int n);
      repeat (P_GAP) @(negedge i_mclk);
      bits_a = '0;
      bits_b = '0;
      drv = '0;
      hold_v = '0;
      o_cs_n <= 1'b0;
      half();
      for (int p = 0; p < n; p++) begin
         // bits taken at the end of the high phase
         if (p < 32) begin
            bits_a[p] = i_first;
            bits_b[p] = i_second;
            drv[p] = (i_first_oe_n === 1'b0) && (i_second_oe_n === 1'b0);
            hold_v[p] = i_hold;
         end
         o_sclk <= 1'b0;
         half();
         o_sclk <= 1'b1;
         half();
      end
      repeat (8) @(negedge i_mclk);
      float_end = (i_first_oe_n === 1'b1) && (i_second_oe_n === 1'b1);
      o_cs_n <= 1'b1;
   endtask
endmodule

// ==== tb/dual_adc_serial_power_modes_tb_top.sv ====
// self-checking bench of the dual converter serial and power control
`timescale 1ns/100ps
module dual_adc_serial_power_modes_tb_top;
   import das_pkg::*;
   logic      i_mclk;
   logic      i_rst;
   logic      i_cs_n;
   logic      i_sclk;
   das_res_t  i_res;
   logic      i_res_valid;
   logic      o_res_ready;
   logic      o_first;
   logic      o_first_oe_n;
   logic      o_second;
   logic      o_second_oe_n;
   das_ana_t  o_ana;
   logic      o_conv_start;
   logic      o_conv_abort;
   logic      o_pwr_ok;
   das_mode_t o_mode;
   das_mode_t exp_mode;
   das_res_t  q[$];
   int        failures;
   int        tests_run;
   int        starts;
   int        aborts;
   int        exp_starts;
   int        exp_aborts;
   int        seed;
   int        seq[15] = '{14, 16, 32, 40, 1, 11, 5, 1, 10, 2, 9, 3, 12, 0, 20};

   das_ctrl #(.P_PWRUP_CYC(5), .P_FULL_CYC(10)) dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
      .i_res(i_res), .i_res_valid(i_res_valid), .o_res_ready(o_res_ready),
      .o_serial_out_first(o_first), .o_serial_out_first_oe_n(o_first_oe_n),
      .o_serial_out_second(o_second),
      .o_serial_out_second_oe_n(o_second_oe_n), .o_ana(o_ana),
      .o_conv_start(o_conv_start), .o_conv_abort(o_conv_abort),
      .o_pwr_ok(o_pwr_ok), .o_mode(o_mode));

   das_host_model host (
      .i_mclk(i_mclk), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .i_first(o_first),
      .i_first_oe_n(o_first_oe_n), .i_second(o_second),
      .i_second_oe_n(o_second_oe_n), .i_hold(o_ana.hold));

   // 100 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // counts of start and abort pulses, sampled mid-cycle
   always @(negedge i_mclk) begin
      if (i_rst === 1'b0) begin
         if (o_conv_start === 1'b1) starts++;
         if (o_conv_abort === 1'b1) aborts++;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s seen %h exp %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // one push attempt; ready is steady between rising edges
   task automatic push(input das_res_t w);
      logic rdy;
      @(negedge i_mclk);
      rdy = o_res_ready;
      i_res <= w;
      i_res_valid <= 1'b1;
      @(negedge i_mclk);
      i_res_valid <= 1'b0;
      if (rdy === 1'b1) q.push_back(w);
   endtask

   // expected 32 bits of one line: zero, id, result, zeros, then the other
   function automatic logic [31:0] line_exp(input logic [11:0] x,
                                            input logic [11:0] y,
                                            input logic id);
      logic [31:0] v;
      v = '0;
      v[1] = id;
      v[17] = ~id;
      for (int i = 0; i < 12; i++) begin
         v[2+i] = x[11-i];
         v[18+i] = y[11-i];
      end
      return v;
   endfunction

   function automatic das_mode_t next_mode(input das_mode_t m, input int n);
      if (n >= 10) return DAS_NORMAL;
      if (n < 2) return m;
      return (m == DAS_NORMAL) ? DAS_PARTIAL : DAS_FULL;
   endfunction

   // one frame of n edges, compared with the model
   task automatic run(input int n);
      das_res_t    r;
      logic [31:0] m;
      logic [31:0] hm;
      logic [2:0]  ea;
      logic [31:0] xa;
      logic [31:0] xb;
      r = (q.size() > 0) ? q.pop_front() : '0;
      host.frame(n);
      m = (n >= 32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
      hm = m & 32'hffff_dfff;
      exp_starts++;
      if (n < 14) exp_aborts++;
      exp_mode = next_mode(exp_mode, n);
      ea = (exp_mode == DAS_NORMAL) ? 3'h6 :
           (exp_mode == DAS_PARTIAL) ? 3'h2 : 3'h0;
      repeat (30) @(negedge i_mclk);
      xa = line_exp(r.a, r.b, 1'b0) & m;
      xb = line_exp(r.b, r.a, 1'b1) & m;
      check(host.bits_a & m, xa, "first");
      check(host.bits_b & m, xb, "second");
      check(host.drv & m, m, "driving");
      check(host.hold_v & hm, 32'h0000_1fff & hm, "hold");
      check(host.float_end, n >= 32, "float at 32");
      check({o_first_oe_n, o_second_oe_n}, 2'h3, "float at rise");
      check(o_mode, exp_mode, "mode");
      check(o_ana, ea, "analog");
      check(o_pwr_ok, exp_mode == DAS_NORMAL, "power ok");
      check(starts, exp_starts, "starts");
      check(aborts, exp_aborts, "aborts");
      $display("frame of %0d edges done", n);
   endtask

   // bounded run length
   initial begin
      repeat (90000) @(posedge i_mclk);
      failures++;
      complete_run();
   end

   // main sequence
   initial begin
      seed = 32'h5ce6_4b41;
      i_rst = 1'b1;
      i_res = '0;
      i_res_valid = 1'b0;
      exp_mode = DAS_NORMAL;
      repeat (2) @(negedge i_mclk);
      i_rst <= 1'b0;
      repeat (4) @(negedge i_mclk);
      check({o_first_oe_n, o_second_oe_n, o_ana}, 5'h1e,
            "reset lines");
      check({o_mode, o_pwr_ok, o_res_ready}, 4'h3, "reset state");
      $display("reset test done");
      foreach (seq[i]) begin
         push(das_res_t'(24'($random(seed))));
         run(seq[i]);
      end
      for (int i = 0; i < 20; i++) push(das_res_t'(24'($random(seed))));
      check(q.size(), 16, "fifo fill");
      check(o_res_ready, 1'b0, "fifo full");
      $display("fifo fill test done");
      for (int i = 0; i < 17; i++) run($unsigned($random(seed)) % 41);
      complete_run();
   end
endmodule
